// >>> design/pin_sync.sv
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pinIn,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Change accepted only when second and third stages agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else if (ce) begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> design/reclose_zone_follow_logic.sv
`default_nettype none
module reclose_zone_follow_logic (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic bkrClosedPin,
  input wire logic pickupPin,
  input wire logic tripPin,
  input wire logic blockPin,
  input wire logic lockResetPin,
  input wire logic [1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic closeCmd,
  output logic [reclose_zone_pkg::SHOT_W-1:0] shotNum,
  output logic arReady,
  output logic irq
);
  // Register map, word index on regAddr
  localparam logic [1:0] A_CTRL = 2'h0;
  localparam logic [1:0] A_TIME = 2'h1;
  localparam logic [1:0] A_STAT = 2'h2;
  localparam logic [1:0] A_MASK = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  logic bkrClosed;
  logic pickup;
  logic trip;
  logic block;
  logic lockReset;
  pin_sync uBkr (.clk(clk), .rstn(rstn), .ce(ce), .pinIn(bkrClosedPin), .level(bkrClosed));
  pin_sync uPick (.clk(clk), .rstn(rstn), .ce(ce), .pinIn(pickupPin), .level(pickup));
  pin_sync uTrip (.clk(clk), .rstn(rstn), .ce(ce), .pinIn(tripPin), .level(trip));
  pin_sync uBlk (.clk(clk), .rstn(rstn), .ce(ce), .pinIn(blockPin), .level(block));
  pin_sync uLrs (.clk(clk), .rstn(rstn), .ce(ce), .pinIn(lockResetPin), .level(lockReset));

  ////////////////////////////////////////////////////////////////////////////////
  // Settings: follow enable, max shots, dead time, recovery time, fault time
  logic followEn_q;
  logic [reclose_zone_pkg::SHOT_W-1:0] maxShots_q;
  logic [reclose_zone_pkg::TIME_W-1:0] deadTime_q;
  logic [reclose_zone_pkg::TIME_W-1:0] recoverTime_q;
  logic [reclose_zone_pkg::TIME_W-1:0] faultTime_q;
  logic [reclose_zone_pkg::IRQ_W-1:0] status_q;
  logic [reclose_zone_pkg::IRQ_W-1:0] mask_q;
  logic [1:0] timeSel_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      followEn_q <= 1'b0;
      maxShots_q <= reclose_zone_pkg::MAX_SHOTS_RESET;
      timeSel_q <= 2'h0;
    end else if (ce && regWr && regAddr == A_CTRL) begin
      followEn_q <= regWdata[0];
      maxShots_q <= regWdata[6:4];
      timeSel_q <= regWdata[9:8];
    end
  end

  // Timer word write goes to the timer picked by CTRL[9:8]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      deadTime_q <= reclose_zone_pkg::DEAD_RESET;
      recoverTime_q <= reclose_zone_pkg::RECOVER_RESET;
      faultTime_q <= reclose_zone_pkg::FAULT_RESET;
    end else if (ce && regWr && regAddr == A_TIME) begin
      case (timeSel_q)
        2'h0: deadTime_q <= regWdata[23:0];
        2'h1: recoverTime_q <= regWdata[23:0];
        2'h2: faultTime_q <= regWdata[23:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_q <= 3'h0;
    end else if (ce && regWr && regAddr == A_MASK) begin
      mask_q <= regWdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  reclose_zone_pkg::arState_t state_q;
  logic [reclose_zone_pkg::TIME_W-1:0] timer_q;
  logic [reclose_zone_pkg::SHOT_W-1:0] shot_q;
  logic pickupPrev_q;
  logic followCycle_q;
  logic evSuccess;
  logic evFailed;
  logic evShot;
  logic timerDone;
  logic pickupDrop;
  logic lockedLast;

  assign timerDone = (timer_q == reclose_zone_pkg::TIMER_RESET);
  assign pickupDrop = pickupPrev_q && !pickup;
  assign lockedLast = (shot_q >= maxShots_q);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pickupPrev_q <= 1'b0;
    end else if (ce) begin
      pickupPrev_q <= pickup;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= reclose_zone_pkg::ST_READY;
      timer_q <= reclose_zone_pkg::TIMER_RESET;
      shot_q <= reclose_zone_pkg::SHOT_RESET;
      followCycle_q <= 1'b0;
      closeCmd <= 1'b0;
      evSuccess <= 1'b0;
      evFailed <= 1'b0;
      evShot <= 1'b0;
    end else if (ce) begin
      evSuccess <= 1'b0;
      evFailed <= 1'b0;
      evShot <= 1'b0;
      closeCmd <= 1'b0;
      if (!timerDone) begin
        timer_q <= timer_q - 24'h000001;
      end
      case (state_q)
        reclose_zone_pkg::ST_READY: begin
          shot_q <= reclose_zone_pkg::SHOT_RESET;
          if (block) begin
            state_q <= reclose_zone_pkg::ST_BLOCKED;
          end else if (bkrClosed && (pickup || trip)) begin
            state_q <= reclose_zone_pkg::ST_RUNNING;
            followCycle_q <= followEn_q;
            timer_q <= faultTime_q;
          end
        end
        reclose_zone_pkg::ST_RUNNING: begin
          if (block) begin
            state_q <= reclose_zone_pkg::ST_BLOCKED;
          end else if (followCycle_q && pickupDrop) begin
            // Downstream recloser cleared the fault; own breaker stays closed
            state_q <= reclose_zone_pkg::ST_DEAD;
            timer_q <= deadTime_q;
          end else if (trip) begin
            state_q <= reclose_zone_pkg::ST_WAIT_OPEN;
            timer_q <= 24'(reclose_zone_pkg::BKR_SUP_CYC);
          end else if (timerDone) begin
            state_q <= reclose_zone_pkg::ST_LOCKOUT;
            evFailed <= 1'b1;
          end
        end
        reclose_zone_pkg::ST_WAIT_OPEN: begin
          if (!bkrClosed) begin
            state_q <= reclose_zone_pkg::ST_DEAD;
            timer_q <= deadTime_q;
          end else if (timerDone) begin
            state_q <= reclose_zone_pkg::ST_LOCKOUT;
            evFailed <= 1'b1;
          end
        end
        reclose_zone_pkg::ST_DEAD: begin
          if (block) begin
            state_q <= reclose_zone_pkg::ST_BLOCKED;
          end else if (timerDone && followCycle_q) begin
            // No close command in follow mode
            shot_q <= shot_q + 3'h1;
            evShot <= 1'b1;
            state_q <= reclose_zone_pkg::ST_RECOVER;
            timer_q <= recoverTime_q;
          end else if (timerDone && !bkrClosed && !pickup && !trip) begin
            shot_q <= shot_q + 3'h1;
            evShot <= 1'b1;
            closeCmd <= 1'b1;
            state_q <= reclose_zone_pkg::ST_RECLOSE;
            timer_q <= 24'(reclose_zone_pkg::BKR_SUP_CYC);
          end
        end
        reclose_zone_pkg::ST_RECLOSE: begin
          if (bkrClosed) begin
            state_q <= reclose_zone_pkg::ST_RECOVER;
            timer_q <= recoverTime_q;
          end else if (timerDone) begin
            state_q <= reclose_zone_pkg::ST_LOCKOUT;
            evFailed <= 1'b1;
          end
        end
        reclose_zone_pkg::ST_RECOVER: begin
          if (block) begin
            state_q <= reclose_zone_pkg::ST_BLOCKED;
          end else if (pickup || trip) begin
            if (lockedLast) begin
              state_q <= reclose_zone_pkg::ST_LOCKOUT;
              evFailed <= 1'b1;
            end else begin
              state_q <= reclose_zone_pkg::ST_RUNNING;
              timer_q <= faultTime_q;
            end
          end else if (timerDone) begin
            // Transient fault: no restart, back to ready
            state_q <= reclose_zone_pkg::ST_READY;
            evSuccess <= 1'b1;
          end
        end
        reclose_zone_pkg::ST_LOCKOUT: begin
          if (lockReset && bkrClosed) begin
            state_q <= reclose_zone_pkg::ST_READY;
          end
        end
        reclose_zone_pkg::ST_BLOCKED: begin
          // Block aborts a cycle in running, dead or recovery, not in wait-open or reclose; shot count restarts from ready
          if (!block) begin
            state_q <= reclose_zone_pkg::ST_READY;
          end
        end
        default: state_q <= reclose_zone_pkg::ST_READY;
      endcase
    end
  end

  // Shot number feeds shot-controlled pickup, initiate and blocking functions
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shotNum <= reclose_zone_pkg::SHOT_RESET;
      arReady <= 1'b0;
    end else if (ce) begin
      shotNum <= shot_q;
      arReady <= (state_q == reclose_zone_pkg::ST_READY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear; a new event wins over the clear
  logic [reclose_zone_pkg::IRQ_W-1:0] events;
  logic [reclose_zone_pkg::IRQ_W-1:0] clrMask;
  always_comb begin
    events = '0;
    events[reclose_zone_pkg::IRQ_SUCCESS] = evSuccess;
    events[reclose_zone_pkg::IRQ_FAILED] = evFailed;
    events[reclose_zone_pkg::IRQ_SHOT] = evShot;
    clrMask = (regWr && regAddr == A_STAT) ? regWdata[2:0] : 3'h0;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= 3'h0;
      irq <= 1'b0;
    end else if (ce) begin
      status_q <= (status_q & ~clrMask) | events;
      irq <= |(((status_q & ~clrMask) | events) & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port, data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regRdata <= 32'h00000000;
    end else if (ce) begin
      regRdata <= 32'h00000000;
      if (regRd) begin
        case (regAddr)
          A_CTRL: regRdata <= {22'h0, timeSel_q, 1'b0, maxShots_q, 3'h0, followEn_q};
          A_TIME: regRdata <= {25'h0, 4'(state_q), shot_q};
          A_STAT: regRdata <= {29'h0, status_q};
          A_MASK: regRdata <= {29'h0, mask_q};
          default: regRdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // reclose_zone_follow_logic
`default_nettype wire

// >>> design/reclose_zone_pkg.sv
`default_nettype none
package reclose_zone_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int SHOT_W = 3;
  localparam int TIME_W = 24;
  localparam logic [SHOT_W-1:0] SHOT_RESET = 3'h0;
  localparam logic [TIME_W-1:0] TIMER_RESET = 24'h000000;
  localparam logic [SHOT_W-1:0] MAX_SHOTS_RESET = 3'h1;
  // Timer reset values, in clock cycles
  localparam logic [TIME_W-1:0] DEAD_RESET = 24'h0003e8;
  localparam logic [TIME_W-1:0] RECOVER_RESET = 24'h0007d0;
  localparam logic [TIME_W-1:0] FAULT_RESET = 24'h000fa0;
  // Breaker supervision window used by the ordinary cycle, 200 ms
  localparam int BKR_SUP_MS = 200;
  localparam int BKR_SUP_CYC = BKR_SUP_MS * (CLK_HZ / 1000);
  localparam int IRQ_W = 3;
  localparam int IRQ_SUCCESS = 0;
  localparam int IRQ_FAILED = 1;
  localparam int IRQ_SHOT = 2;
  typedef enum logic [2:0] {
    ST_READY, ST_RUNNING, ST_WAIT_OPEN, ST_DEAD, ST_RECLOSE, ST_RECOVER, ST_LOCKOUT, ST_BLOCKED
  } arState_t;
endpackage
`default_nettype wire

// >>> test/feeder_partner.sv
`default_nettype none
module feeder_partner (
  input wire logic clk,
  input wire logic faultOn,
  input wire logic tripEn,
  input wire logic [3:0] pickDly,
  input wire logic closeCmd,
  output logic bkrClosed,
  output logic pickup,
  output logic trip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dwell = 8'h0;
  initial bkrClosed = 1'h1;
  initial pickup = 1'h0;
  initial trip = 1'h0;
  // Fault current flows only through a closed breaker
  always @(posedge clk) begin
    dwell <= (faultOn && bkrClosed) ? dwell + 8'h1 : 8'h0;
    pickup <= faultOn && bkrClosed && dwell >= {4'h0, pickDly};
    trip <= tripEn && pickup && dwell > {4'h0, pickDly} + 8'h8;
    if (trip)
      bkrClosed <= 1'h0;
    else if (closeCmd)
      bkrClosed <= 1'h1;
  end
endmodule // feeder_partner
`default_nettype wire

// >>> test/reclose_zone_follow_logic_bench.sv
`default_nettype none
module reclose_zone_follow_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rstn = 1'h0, regWr = 1'h0, regRd = 1'h0, faultOn = 1'h0, tripEn = 1'h0;
  logic blockPin = 1'h0, lockResetPin = 1'h0, closeSeen = 1'h0, rdPend = 1'h0, ce = 1'h1;
  logic [1:0] regAddr = 2'h0;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [3:0] pickDly = 4'h2;
  logic closeCmd, bkrClosed, pickup, trip, arReady, irq;
  logic [reclose_zone_pkg::SHOT_W-1:0] shotNum;
  logic [31:0] expQ[$];
  int mismatches = 0, compares = 0, seed = 18015;
  always #12.5 clk = ~clk;
  feeder_partner far (.clk(clk), .faultOn(faultOn), .tripEn(tripEn), .pickDly(pickDly),
    .closeCmd(closeCmd), .bkrClosed(bkrClosed), .pickup(pickup), .trip(trip));
  reclose_zone_follow_logic dut (.clk(clk), .rstn(rstn), .ce(ce), .bkrClosedPin(bkrClosed),
    .pickupPin(pickup), .tripPin(trip), .blockPin(blockPin), .lockResetPin(lockResetPin),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .closeCmd(closeCmd), .shotNum(shotNum), .arReady(arReady), .irq(irq));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    expQ.push_back(e);
    @(posedge clk);
    regRd <= 1'h0;
  endtask
  // Bounded wait: 0 ready, 1 shot value, 2 breaker open
  task automatic waitOn(input int what, input logic [2:0] v);
    int n;
    for (n = 0; n < 3000; n++) begin
      if ((what == 0 && arReady === 1'h1) || (what == 1 && shotNum === v)
          || (what == 2 && bkrClosed === 1'h0))
        break;
      @(posedge clk);
    end
    chk("wait", 32'h1, {31'h0, n < 3000});
  endtask
  task automatic fault();
    int len;
    len = 12 + ($random(seed) & 15);
    @(posedge clk);
    pickDly <= 4'($random(seed) & 7);
    faultOn <= 1'h1;
    repeat (len) @(posedge clk);
    faultOn <= 1'h0;
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Read data stand one cycle only, so they are taken at the edge ending it
  always @(posedge clk) begin
    if (rdPend)
      chk("regRdata", expQ.pop_front(), regRdata);
    rdPend <= regRd;
    if (closeCmd)
      closeSeen <= 1'h1;
  end
  initial begin
    #(25 * 20000);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    waitOn(0, 3'h0);
    rd(2'h0, 32'h10);
    rd(2'h2, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(2'h0, 32'h21 | (32'(i) << 8));
      wr(2'h1, (i == 0) ? 32'h14 : (i == 1) ? 32'h50 : 32'h190);
    end
    wr(2'h3, 32'h7);
    fault();
    waitOn(1, 3'h1);
    rd(2'h1, 32'h29);
    waitOn(0, 3'h0);
    rd(2'h2, 32'h5);
    chk("closeSeen", 32'h0, {31'h0, closeSeen});
    chk("irq", 32'h1, {31'h0, irq});
    wr(2'h2, 32'h7);
    rd(2'h2, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("Test transient done");
    wr(2'h3, 32'h0);
    fault();
    waitOn(1, 3'h1);
    fault();
    waitOn(1, 3'h2);
    faultOn <= 1'h1;
    repeat (24) @(posedge clk);
    rd(2'h1, 32'h32);
    rd(2'h2, 32'h6);
    chk("irq", 32'h0, {31'h0, irq});
    faultOn <= 1'h0;
    lockResetPin <= 1'h1;
    waitOn(0, 3'h0);
    lockResetPin <= 1'h0;
    wr(2'h2, 32'h7);
    $display("Test persistent done");
    wr(2'h0, 32'h20);
    tripEn <= 1'h1;
    faultOn <= 1'h1;
    waitOn(2, 3'h0);
    faultOn <= 1'h0;
    waitOn(0, 3'h0);
    chk("closeSeen", 32'h1, {31'h0, closeSeen});
    rd(2'h1, 32'h0);
    rd(2'h2, 32'h5);
    $display("Test ordinary done");
    tripEn <= 1'h0;
    blockPin <= 1'h1;
    fault();
    chk("arReady", 32'h0, {31'h0, arReady});
    blockPin <= 1'h0;
    waitOn(0, 3'h0);
    rd(2'h1, 32'h0);
    $display("Test block done");
    // A write while the clock enable is low must leave the settings alone
    ce <= 1'h0;
    wr(2'h0, 32'h0);
    ce <= 1'h1;
    rd(2'h0, 32'h20);
    $display("Test enable done");
    give_verdict();
  end
endmodule // reclose_zone_follow_logic_bench
`default_nettype wire

// >>> test/reclose_zone_follow_logic_sva.sv
`default_nettype none
module reclose_zone_follow_logic_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic closeCmd,
  input wire logic [reclose_zone_pkg::SHOT_W-1:0] shotNum,
  input wire logic arReady,
  input wire logic irq
);
  logic followQ;
  logic [2:0] maxQ;
  logic [2:0] maskQ;
  // Shadow of control and mask, rebuilt from the write strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      followQ <= 1'h0;
      maxQ <= 3'h1;
      maskQ <= 3'h0;
    end else if (ce && regWr && regAddr == 2'h0) begin
      followQ <= regWdata[0];
      maxQ <= regWdata[6:4];
    end else if (ce && regWr && regAddr == 2'h3) begin
      maskQ <= regWdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence shotAdv;
    $changed(shotNum) && shotNum != 3'h0;
  endsequence
  sequence readShot;
    regRd && regAddr == 2'h1;
  endsequence
  AST_NO_CLOSE_FOLLOW: assert property (followQ |-> !closeCmd)
    else $error("close in follow mode");
  AST_CLOSE_PULSE: assert property (closeCmd |=> !closeCmd)
    else $error("close too long");
  AST_SHOT_STEP: assert property ($changed(shotNum) |->
    shotNum == 3'h0 || shotNum == $past(shotNum) + 3'h1) else $error("shot jump");
  AST_SHOT_MAX: assert property (shotNum <= maxQ)
    else $error("shot above max");
  AST_READY_SHOT: assert property (arReady && $past(arReady) |-> shotNum == 3'h0)
    else $error("shot kept in ready");
  // Recovery is loaded far above eight cycles by the bench
  AST_RECOVER_HOLD: assert property (shotAdv |-> !arReady [*8])
    else $error("recovery cut short");
  // Both read data and shot output lag the counter by one cycle
  AST_READ_SHOT: assert property (readShot |=> regRdata[2:0] == shotNum)
    else $error("shot readback");
  AST_RDATA_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside slot");
  AST_IRQ_MASKED: assert property (maskQ == 3'h0 && $past(maskQ) == 3'h0 |-> !irq)
    else $error("masked interrupt");
endmodule // reclose_zone_follow_logic_sva
bind reclose_zone_follow_logic reclose_zone_follow_logic_sva chk (.clk(clk), .rstn(rstn), .ce(ce),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .closeCmd(closeCmd), .shotNum(shotNum), .arReady(arReady), .irq(irq));
`default_nettype wire
